// File: tb/vdio_bank_tb_top.sv
`timescale 1ns/1ps
module vdio_bank_tb_top;
    import vdio_pkg::*;

    // Design signals
    logic             hclk = 1'b0;
    logic             hresetn, hsel, hwrite, hreadyout, hresp, irq;
    logic [31:0]      haddr, hwdata, hrdata;
    logic [1:0]       htrans;
    logic [2:0]       hsize;
    logic             drive_running, function_conflict_fault;
    logic [63:0]      phys_func;
    logic [15:0]      nv_poweron_word, nv_store_word, vout_func_active;
    logic [15:0]      virtual_input_active, virtual_output_level;
    // Bench state
    int               miscompares = 0;
    int               checks = 0;
    int               pulses = 0;
    int               pulse_base = 0;
    logic [31:0]      rd;
    logic             ok;
    logic [15:0]      pw, v, lg, idle, act;
    logic [15:0][7:0] fn;
    logic [7:0]       c;
    logic [7:0]       offs [6] = '{OFF_VIN_EN, OFF_VIN_DEF, OFF_VOUT_EN,
                                   OFF_VOUT_IDLE, OFF_VOUT_DISP, 8'h30};

    always #50 hclk = ~hclk;

    // Count cycles in which input 0 is active
    always @(posedge hclk) if (virtual_input_active[0] === 1'b1) pulses++;

    vdio_host_model vdio_host_model_inst (.hclk, .hready(hreadyout),
        .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);

    vdio_bank vdio_bank_inst (.hclk, .hresetn, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
        .hresp, .drive_running, .nv_poweron_word, .phys_func,
        .vout_func_active, .nv_store_word, .virtual_input_active,
        .virtual_output_level, .function_conflict_fault, .irq);

    // Verdict and end of run
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test

    // Compare and report
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Bus access; a hang ends the run
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        vdio_host_model_inst.xfer(w, a, d, rd, ok);
        if (!ok) begin
            miscompares++;
            $display("MISMATCH at %0t: bus timeout", $time);
            finish_test();
        end
    endtask : bus

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rd, exp);
        check(hresp, 1'b0);
    endtask : rdchk

    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask : tick

    // Expected output levels: idle word for no function, else polarity
    function automatic logic [15:0] exp_out(input logic [15:0][7:0] f,
        input logic [15:0] a, input logic [15:0] l, input logic [15:0] d);
        logic [15:0] r;
        for (int i = 0; i < 16; i++)
            r[i] = (f[i] == 8'h00) ? d[i] : a[i] ^ l[i];
        return r;
    endfunction : exp_out

    initial begin
        void'($urandom(15284));
        hresetn = 1'b0;
        drive_running = 1'b0;
        phys_func = '0;
        vout_func_active = '0;
        pw = 16'($urandom);
        nv_poweron_word = pw;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        // Reset values, unmapped word, power-on levels
        foreach (offs[i]) rdchk(offs[i], 32'h0);
        rdchk(OFF_VIN_LVL, {16'h0, pw});
        bus(1'b1, OFF_VIN_EN, 32'h1);
        rdchk(OFF_VIN_EN, 32'h1);
        tick(3);
        check(virtual_input_active, pw);
        check(function_conflict_fault, 1'b0);
        v = 16'($urandom);
        bus(1'b1, OFF_VIN_DEF, {16'h0, v});
        check(nv_store_word, v);
        rdchk(OFF_VIN_LVL, {16'h0, pw});
        // Level word while running, at-stop words refused
        drive_running <= 1'b1;
        repeat (4) begin
            lg = 16'($urandom);
            bus(1'b1, OFF_VIN_LVL, {16'h0, lg});
            tick(3);
            check(virtual_input_active, lg);
        end
        bus(1'b1, OFF_VIN_EN, 32'h0);
        bus(1'b1, OFF_VIN_DEF, {16'h0, ~v});
        bus(1'b1, OFF_VOUT_EN, 32'h1);
        bus(1'b1, OFF_VOUT_IDLE, 32'hFFFF);
        bus(1'b1, OFF_VOUT_DISP, 32'hFFFF);
        rdchk(OFF_VIN_EN, 32'h1);
        rdchk(OFF_VIN_DEF, {16'h0, v});
        rdchk(OFF_VOUT_EN, 32'h0);
        rdchk(OFF_VOUT_IDLE, 32'h0);
        rdchk(OFF_VOUT_DISP, 32'h0);
        drive_running <= 1'b0;
        // Edge mode: one pulse per rising level, event interrupt
        bus(1'b1, OFF_VIN_LVL, 32'h0);
        bus(1'b1, OFF_VIN_LOGIC, 32'h1);
        bus(1'b1, OFF_IRQ_MASK, 32'h2);
        tick(3);
        pulse_base = pulses;
        bus(1'b1, OFF_VIN_LVL, 32'h1);
        bus(1'b1, OFF_VIN_LVL, 32'h1);
        tick(3);
        check(pulses - pulse_base, 32'h1);
        rdchk(OFF_IRQ_STAT, 32'h2);
        check(irq, 1'b1);
        bus(1'b1, OFF_IRQ_MASK, 32'h0);
        tick(2);
        check(irq, 1'b0);
        bus(1'b1, OFF_IRQ_STAT, 32'h2);
        rdchk(OFF_IRQ_STAT, 32'h0);
        // Function conflict on input 6 against terminal 3
        c = 8'($urandom) | 8'h01;
        phys_func <= {32'h0, c, 24'h0};
        bus(1'b1, {SEG_VIN_FUNC, 4'h4}, {8'h0, c, 16'h0});
        bus(1'b1, OFF_IRQ_MASK, 32'h1);
        tick(3);
        check(function_conflict_fault, 1'b1);
        check(irq, 1'b1);
        phys_func <= {32'h0, ~c, 24'h0};
        tick(3);
        check(function_conflict_fault, 1'b0);
        bus(1'b1, OFF_IRQ_STAT, 32'h1);
        rdchk(OFF_IRQ_STAT, 32'h0);
        check(irq, 1'b0);
        // Outputs: disabled first, then random functions and polarity
        for (int i = 0; i < 4; i++) begin
            foreach (fn[j]) fn[j] = ($urandom % 2) ? 8'($urandom) : 8'h00;
            if (i == 1) fn[2] = 8'h00; // Idle-word output while enabled
            if (i == 2) fn[3] = 8'h05; // Driven output while enabled
            lg   = 16'($urandom);
            act  = 16'($urandom);
            idle = ~(act ^ lg);
            bus(1'b1, OFF_VOUT_EN, (i == 0) ? 32'h0 : 32'h1);
            for (int k = 0; k < 4; k++)
                bus(1'b1, {SEG_VOUT_FUNC, 4'(4 * k)}, fn[4 * k +: 4]);
            bus(1'b1, OFF_VOUT_LOGIC, {16'h0, lg});
            bus(1'b1, OFF_VOUT_IDLE, {16'h0, idle});
            vout_func_active <= act;
            tick(3);
            v = (i == 0) ? 16'h0 : exp_out(fn, act, lg, idle);
            check(virtual_output_level, v);
            rdchk(OFF_VOUT_DISP, {16'h0, v});
        end
        // Second power-on: the stored word reaches the level word, inputs stay disabled
        pw = 16'($urandom);
        bus(1'b1, OFF_VIN_DEF, {16'h0, pw});
        nv_poweron_word <= nv_store_word;
        hresetn <= 1'b0;
        tick(2);
        hresetn <= 1'b1;
        rdchk(OFF_VIN_LVL, {16'h0, pw});
        rdchk(OFF_VIN_DEF, 32'h0);
        check(virtual_input_active, 16'h0);
        check(virtual_output_level, 16'h0);
        finish_test();
    end
endmodule : vdio_bank_tb_top

// File: tb/vdio_host_model.sv
`timescale 1ns/1ps
// Host side bus master issuing single whole-word transfers
module vdio_host_model (
    // Clock and response
    input  wire logic                        hclk,
    input  wire logic                        hready,
    input  wire logic [vdio_pkg::DATA_W-1:0] hrdata,
    // Request
    output logic                             hsel,
    output logic      [vdio_pkg::ADDR_W-1:0] haddr,
    output logic      [1:0]                  htrans,
    output logic                             hwrite,
    output logic      [2:0]                  hsize,
    output logic      [vdio_pkg::DATA_W-1:0] hwdata
);
    import vdio_pkg::*;

    // Idle bus at time zero
    initial begin
        hsel   = 1'b0;
        haddr  = '0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = '0;
    end

    // Wait a bounded number of edges for hready sampled high
    task automatic wait_ready(output logic ok);
        ok = 1'b0;
        for (int n = 0; n < 40 && !ok; n++) begin
            @(posedge hclk);
            ok = (hready === 1'b1);
        end
    endtask : wait_ready

    // One transfer; ok low when the slave never answered
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] wd,
                        output logic [31:0] rd, output logic ok);
        rd = '0;
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_ready(ok);
        if (!ok) return;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready(ok);
        rd = hrdata;
        hsel   <= 1'b0;
        hwdata <= ~wd; // Released data never shows the old value
    endtask : xfer
endmodule : vdio_host_model

// File: verilog/vdio_bank.sv
// The placing of the registers and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
module vdio_bank (
    // Clock and reset
    input  wire logic                         hclk,
    input  wire logic                         hresetn,
    // AHB-Lite slave
    input  wire logic                         hsel,
    input  wire logic [vdio_pkg::ADDR_W-1:0]  haddr,
    input  wire logic [1:0]                   htrans,
    input  wire logic                         hwrite,
    input  wire logic [2:0]                   hsize,
    input  wire logic [vdio_pkg::DATA_W-1:0]  hwdata,
    input  wire logic                         hready,
    output logic      [vdio_pkg::DATA_W-1:0]  hrdata,
    output logic                              hreadyout,
    output logic                              hresp,
    // Drive state and terminal side
    input  wire logic                         drive_running,
    input  wire logic [vdio_pkg::NVIO-1:0]    nv_poweron_word,
    input  wire logic [vdio_pkg::NPHYS*vdio_pkg::FUNC_W-1:0] phys_func,
    input  wire logic [vdio_pkg::NVIO-1:0]    vout_func_active,
    output logic      [vdio_pkg::NVIO-1:0]    nv_store_word,
    output logic      [vdio_pkg::NVIO-1:0]    virtual_input_active,
    output logic      [vdio_pkg::NVIO-1:0]    virtual_output_level,
    output logic                              function_conflict_fault,
    output logic                              irq
);
    import vdio_pkg::*;

    // ********************************************************
    // Storage
    // ********************************************************
    vdio_bus_t                    bus_state_reg;
    logic [7:0]                   addr_reg;
    logic                         wr_reg;
    logic                         vin_en_reg;
    logic                         vout_en_reg;
    logic [NVIO-1:0]              vin_def_reg;
    logic [NVIO-1:0]              vin_lvl_reg;
    logic [NVIO-1:0]              vin_prev_reg;
    logic [NVIO-1:0]              vin_logic_reg;
    logic [NVIO-1:0]              vout_idle_reg;
    logic [NVIO-1:0]              vout_logic_reg;
    logic [NVIO-1:0][FUNC_W-1:0]  vin_func_reg;
    logic [NVIO-1:0][FUNC_W-1:0]  vout_func_reg;
    logic [NSTAT-1:0]             stat_reg;
    logic [NSTAT-1:0]             mask_reg;
    logic                         boot_done_reg;
    logic [DATA_W-1:0]            hrdata_reg;
    logic                         hreadyout_reg;
    logic [NVIO-1:0]              vin_act_reg;
    logic [NVIO-1:0]              vout_lvl_reg;
    logic                         conflict_reg;
    logic                         irq_reg;

    // ********************************************************
    // Helpers
    // ********************************************************
    // Matches a latched byte address against a register offset
    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    // Packs four function codes of one word of a table
    function automatic logic [DATA_W-1:0] func_word(
        input logic [NVIO-1:0][FUNC_W-1:0] tbl,
        input logic [1:0]                  k);
        func_word = {tbl[{k, 2'b11}], tbl[{k, 2'b10}],
                     tbl[{k, 2'b01}], tbl[{k, 2'b00}]};
    endfunction : func_word

    logic addr_take;
    logic wr_now;
    logic stopped;
    logic [NVIO-1:0] vin_rise;
    logic [NVIO-1:0] vin_edge_ev;
    logic [NVIO-1:0] vin_clash;
    logic [NVIO-1:0] vout_next;
    logic conflict_now;

    // Address phase accepted, write data phase, at-stop window
    assign addr_take = hsel & htrans[1] & hready;
    assign wr_now    = (bus_state_reg == BUS_DATA) & wr_reg;
    assign stopped   = ~drive_running;

    // ********************************************************
    // Per-terminal logic
    // ********************************************************
    genvar gi;
    genvar gj;
    generate
        for (gi = 0; gi < NVIO; gi++) begin : g_term
            logic [NPHYS-1:0] same;
            for (gj = 0; gj < NPHYS; gj++) begin : g_phys
                // Same nonzero code as a physical terminal
                assign same[gj] = (vin_func_reg[gi] != FUNC_NONE) &&
                    (vin_func_reg[gi] ==
                     phys_func[gj*FUNC_W +: FUNC_W]);
            end
            assign vin_clash[gi] = |same;
            // Rising change of the level bit
            assign vin_rise[gi]    = vin_lvl_reg[gi] & ~vin_prev_reg[gi];
            assign vin_edge_ev[gi] = vin_logic_reg[gi] & vin_rise[gi];
            // Idle default for function 0, else polarity-applied level
            assign vout_next[gi] = (vout_func_reg[gi] == FUNC_NONE) ?
                vout_idle_reg[gi] :
                (vout_func_active[gi] ^ vout_logic_reg[gi]);
        end
    endgenerate

    assign conflict_now = vin_en_reg & (|vin_clash);

    // ********************************************************
    // AHB-Lite slave
    // ********************************************************
    // Every transfer takes one wait state so read data comes from a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_state_reg <= BUS_IDLE;
            addr_reg      <= 8'h00;
            wr_reg        <= 1'b0;
            hreadyout_reg <= 1'b1;
        end else if (bus_state_reg == BUS_DATA) begin
            bus_state_reg <= BUS_IDLE;
            hreadyout_reg <= 1'b1;
        end else if (addr_take) begin
            bus_state_reg <= BUS_DATA;
            addr_reg      <= {haddr[7:2], 2'b00};
            wr_reg        <= hwrite;
            hreadyout_reg <= 1'b0;
        end
    end

    // Read data mux, unmapped addresses read as zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= 32'h00000000;
        end else if ((bus_state_reg == BUS_DATA) && !wr_reg) begin
            hrdata_reg <= 32'h00000000;
            if (hit(addr_reg, OFF_VIN_EN))
                hrdata_reg[0] <= vin_en_reg;
            if (hit(addr_reg, OFF_VIN_DEF))
                hrdata_reg[15:0] <= vin_def_reg;
            if (hit(addr_reg, OFF_VIN_LVL))
                hrdata_reg[15:0] <= vin_lvl_reg;
            if (hit(addr_reg, OFF_VOUT_EN))
                hrdata_reg[0] <= vout_en_reg;
            if (hit(addr_reg, OFF_VOUT_IDLE))
                hrdata_reg[15:0] <= vout_idle_reg;
            if (hit(addr_reg, OFF_VOUT_DISP))
                hrdata_reg[15:0] <= vout_lvl_reg;
            if (hit(addr_reg, OFF_VIN_LOGIC))
                hrdata_reg[15:0] <= vin_logic_reg;
            if (hit(addr_reg, OFF_VOUT_LOGIC))
                hrdata_reg[15:0] <= vout_logic_reg;
            if (hit(addr_reg, OFF_IRQ_STAT))
                hrdata_reg[NSTAT-1:0] <= stat_reg;
            if (hit(addr_reg, OFF_IRQ_MASK))
                hrdata_reg[NSTAT-1:0] <= mask_reg;
            if (addr_reg[7:4] == SEG_VIN_FUNC)
                hrdata_reg <= func_word(vin_func_reg, addr_reg[3:2]);
            if (addr_reg[7:4] == SEG_VOUT_FUNC)
                hrdata_reg <= func_word(vout_func_reg, addr_reg[3:2]);
        end
    end

    // ********************************************************
    // Configuration registers
    // ********************************************************
    // Settings that may only change while the drive is stopped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vin_en_reg    <= RST_EN;
            vout_en_reg   <= RST_EN;
            vin_def_reg   <= RST_WORD;
            vout_idle_reg <= RST_WORD;
        end else if (wr_now && stopped) begin
            if (hit(addr_reg, OFF_VIN_EN))
                vin_en_reg <= hwdata[0];
            if (hit(addr_reg, OFF_VOUT_EN))
                vout_en_reg <= hwdata[0];
            if (hit(addr_reg, OFF_VIN_DEF))
                vin_def_reg <= hwdata[15:0];
            if (hit(addr_reg, OFF_VOUT_IDLE))
                vout_idle_reg <= hwdata[15:0];
        end
    end

    // Polarity settings and function tables
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vin_logic_reg  <= RST_WORD;
            vout_logic_reg <= RST_WORD;
            vin_func_reg   <= '0;
            vout_func_reg  <= '0;
        end else if (wr_now) begin
            if (hit(addr_reg, OFF_VIN_LOGIC))
                vin_logic_reg <= hwdata[15:0];
            if (hit(addr_reg, OFF_VOUT_LOGIC))
                vout_logic_reg <= hwdata[15:0];
            for (int j = 0; j < 4; j++) begin
                if (addr_reg[7:4] == SEG_VIN_FUNC)
                    vin_func_reg[{addr_reg[3:2], 2'(j)}] <=
                        hwdata[j*FUNC_W +: FUNC_W];
                if (addr_reg[7:4] == SEG_VOUT_FUNC)
                    vout_func_reg[{addr_reg[3:2], 2'(j)}] <=
                        hwdata[j*FUNC_W +: FUNC_W];
            end
        end
    end

    // ********************************************************
    // Virtual input levels
    // ********************************************************
    // First cycle after reset loads the stored word, then host writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            boot_done_reg <= 1'b0;
            vin_lvl_reg   <= RST_WORD;
        end else if (!boot_done_reg) begin
            boot_done_reg <= 1'b1;
            vin_lvl_reg   <= nv_poweron_word;
        end else if (wr_now && hit(addr_reg, OFF_VIN_LVL)) begin
            vin_lvl_reg   <= hwdata[15:0];
        end
    end

    // Level or single-cycle edge activity, gated by the enable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vin_prev_reg <= RST_WORD;
            vin_act_reg  <= RST_WORD;
        end else begin
            vin_prev_reg <= vin_lvl_reg;
            vin_act_reg  <= {NVIO{vin_en_reg}} &
                ((vin_logic_reg & vin_rise) |
                 (~vin_logic_reg & vin_lvl_reg));
        end
    end

    // ********************************************************
    // Virtual output levels
    // ********************************************************
    // Display word follows the outputs, zero while disabled
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vout_lvl_reg <= RST_WORD;
        end else begin
            vout_lvl_reg <= vout_en_reg ? vout_next : RST_WORD;
        end
    end

    // ********************************************************
    // Fault and interrupts
    // ********************************************************
    // Sticky status, write one to clear, a new event wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_reg     <= '0;
            mask_reg     <= '0;
            conflict_reg <= 1'b0;
            irq_reg      <= 1'b0;
        end else begin
            conflict_reg <= conflict_now;
            irq_reg      <= |(stat_reg & mask_reg);
            if (wr_now && hit(addr_reg, OFF_IRQ_MASK))
                mask_reg <= hwdata[NSTAT-1:0];
            stat_reg <= (stat_reg &
                ~((wr_now && hit(addr_reg, OFF_IRQ_STAT)) ?
                  hwdata[NSTAT-1:0] : 2'b00)) |
                {vin_en_reg & (|vin_edge_ev), conflict_now};
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    assign hrdata                  = hrdata_reg;
    assign hreadyout               = hreadyout_reg;
    assign hresp                   = 1'b0;
    assign nv_store_word           = vin_def_reg;
    assign virtual_input_active    = vin_act_reg;
    assign virtual_output_level    = vout_lvl_reg;
    assign function_conflict_fault = conflict_reg;
    assign irq                     = irq_reg;

    // ********************************************************
    // Assertions
    // ********************************************************
    a_bus_wait_state: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (addr_take && bus_state_reg == BUS_IDLE) |=>
        !hreadyout ##1 hreadyout)
        else $error("transfer did not take exactly one wait state");

    a_vin_edge_pulse: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (vin_en_reg && vin_logic_reg[0] && vin_lvl_reg[0]) ##1
        (vin_lvl_reg[0] && vin_logic_reg[0] && vin_en_reg) |=>
        !virtual_input_active[0])
        else $error("edge input stayed active on a steady level");

    a_vin_edge_rise: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (vin_en_reg && vin_logic_reg[0] && vin_lvl_reg[0] &&
         !vin_prev_reg[0]) |=> virtual_input_active[0])
        else $error("edge input missed a rising level bit");

    a_vin_level_mode: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (vin_en_reg && !vin_logic_reg[1]) |=>
        virtual_input_active[1] == $past(vin_lvl_reg[1]))
        else $error("level input does not follow its level bit");

    a_vin_disabled: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !vin_en_reg |=> virtual_input_active == 16'h0000)
        else $error("input active while inputs disabled");

    a_boot_load: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !boot_done_reg |=> vin_lvl_reg == $past(nv_poweron_word))
        else $error("power-on default word not loaded");

    a_level_write: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (boot_done_reg && wr_now && addr_reg == OFF_VIN_LVL) |=>
        vin_lvl_reg == $past(hwdata[15:0]))
        else $error("level word write not applied");

    a_stop_lock: assert property (
        @(posedge hclk) disable iff (!hresetn)
        drive_running |=> $stable(vin_def_reg) && $stable(vin_en_reg) &&
        $stable(vout_idle_reg) && $stable(vout_en_reg))
        else $error("at-stop setting changed while running");

    a_vout_idle: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (vout_en_reg && vout_func_reg[2] == FUNC_NONE) |=>
        virtual_output_level[2] == $past(vout_idle_reg[2]))
        else $error("function 0 output not at idle default");

    a_vout_polarity: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (vout_en_reg && vout_func_reg[3] != FUNC_NONE) |=>
        virtual_output_level[3] ==
        ($past(vout_func_active[3]) ^ $past(vout_logic_reg[3])))
        else $error("output polarity wrong");

    a_vout_disabled: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !vout_en_reg |=> virtual_output_level == 16'h0000)
        else $error("output level shown while outputs disabled");

    a_conflict_flag: assert property (
        @(posedge hclk) disable iff (!hresetn)
        conflict_now |=> function_conflict_fault && stat_reg[STAT_CONFLICT])
        else $error("function conflict not raised");

    a_irq_follows: assert property (
        @(posedge hclk) disable iff (!hresetn)
        1'b1 |=> irq == |$past(stat_reg & mask_reg))
        else $error("interrupt does not follow masked status");

endmodule : vdio_bank

// File: verilog/vdio_pkg.sv
package vdio_pkg;

    // ********************************************************
    // Widths and counts
    // ********************************************************
    localparam int DATA_W  = 32;
    localparam int ADDR_W  = 32;
    localparam int NVIO    = 16;
    localparam int FUNC_W  = 8;
    localparam int NPHYS   = 8;
    localparam int NSTAT   = 2;

    // ********************************************************
    // Register byte offsets
    // ********************************************************
    localparam logic [7:0] OFF_VIN_EN     = 8'h00;
    localparam logic [7:0] OFF_VIN_DEF    = 8'h04;
    localparam logic [7:0] OFF_VIN_LVL    = 8'h08;
    localparam logic [7:0] OFF_VOUT_EN    = 8'h0C;
    localparam logic [7:0] OFF_VOUT_IDLE  = 8'h10;
    localparam logic [7:0] OFF_VOUT_DISP  = 8'h14;
    localparam logic [7:0] OFF_VIN_LOGIC  = 8'h18;
    localparam logic [7:0] OFF_VOUT_LOGIC = 8'h1C;
    localparam logic [7:0] OFF_IRQ_STAT   = 8'h20;
    localparam logic [7:0] OFF_IRQ_MASK   = 8'h24;
    localparam logic [3:0] SEG_VIN_FUNC   = 4'h4;
    localparam logic [3:0] SEG_VOUT_FUNC  = 4'h5;

    // ********************************************************
    // Field positions and reset values
    // ********************************************************
    localparam int STAT_CONFLICT = 0;
    localparam int STAT_VIN_EDGE = 1;
    localparam logic        RST_EN    = 1'b0;
    localparam logic [15:0] RST_WORD  = 16'h0000;
    localparam logic [7:0]  FUNC_NONE = 8'h00;

    // ********************************************************
    // Bus data-phase state
    // ********************************************************
    typedef enum logic {
        BUS_IDLE = 1'b0,
        BUS_DATA = 1'b1
    } vdio_bus_t;

endpackage : vdio_pkg
